//--- hdl/sbst_tap.sv
// sram test access port: tap states, instruction and data registers
// Functional notes
// - three-bit instruction, five defined codes
// - shift in Shift-IR, apply at Update-IR
// - ident captures fixed 32-bit code, shifts out
// - ident current after power-up and reset state
// - sample-z puts boundary chain on data path
// - sample-z floats sram bus until next update
// - sample/preload snapshots pins at Capture-DR
// - controller keeps pins stable, ignores clock bits
// - shift-dr then shifts captured boundary bits
// - preload sets latched boundary outputs
// - capture out and preload in together
// - bypass puts one-bit register in path
// - extest drives preloaded values, chain connected
// - cell 47 gates sram bus under extest
// - latched one drives, zero floats bus
// - shift oe value, latch at Update-DR
// - oe cell preset one at reset
// - Update-IR loads reserved codes too, run as bypass
// - state follows mode select at tck rise
// - opcode values fixed, three reserved
// - Capture-IR loads 01 into low bits
// - five high mode selects reset port, six from a pause state
// - capture on rise, data out on fall
`timescale 1ns/100ps
`default_nettype none
module sbst_tap #(
	parameter int BLEN = sbst_pkg::BSR_LEN
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	sbst_if.dev                  link,
	input  wire logic [BLEN-1:0] pin_in,     // sram pin values to capture
	output logic      [BLEN-1:0] pin_drive,  // values driven under extest
	output logic                 extest_on,  // extest is current
	output logic                 sram_out_en // sram output bus enable
);
	// refuse a chain too short to hold the enable cell
	if (BLEN <= sbst_pkg::OE_CELL)
	begin : g_bad_len
		$error("boundary chain too short for enable cell");
	end

	typedef struct packed {
		sbst_pkg::sbst_state_e st; // tap state
		logic [2:0]     ir_sh;    // instruction shift stage
		logic [2:0]     ir;       // current instruction
		logic [31:0]    id_sh;    // ident shift stage
		logic           byp;      // bypass bit
		logic [BLEN-1:0] bs_sh;   // boundary shift stage
		logic [BLEN-1:0] bs_up;   // boundary update latch
		logic           tck_d;    // previous tck sample
		logic           tdo_o;    // data out value
		logic           tdo_oe;   // data out enable
		logic           ext;      // extest current
		logic           oe;       // sram bus enable
	} sbst_tap_s;

	sbst_tap_s r;       // registered state
	sbst_tap_s next_r;  // next state
	logic [2:0] pins_s; // synchronised tck, tms, tdi
	logic tck_s;
	logic tms_s;
	logic tdi_s;
	logic rise;
	logic fall;
	logic shout;        // serial bit at chain end
	logic [BLEN-1:0] pin_s; // synchronised sram pin values

	sbst_sync #(.W(3)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({link.tck, link.tms, link.tdi}),
		.q       (pins_s)
	);
	// sram pins belong to another clock; two stages before capture
	sbst_sync #(.W(BLEN)) u_pin_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (pin_in),
		.q       (pin_s)
	);
	assign tck_s = pins_s[2];
	assign tms_s = pins_s[1];
	assign tdi_s = pins_s[0];
	assign rise  = tck_s & ~r.tck_d;
	assign fall  = ~tck_s & r.tck_d;

	// next-state logic: register and state work on sampled tck edges; reset reload and bus control every clock
	always_comb
	begin
		next_r = r;
		next_r.tck_d = tck_s;
		shout = 1'b0;
		// chain end: instruction stage in Shift-IR, else selected by instruction
		unique case (r.st)
			sbst_pkg::ST_SH_IR: shout = r.ir_sh[0];
			default:
			begin
				if (r.ir == sbst_pkg::OP_IDENT)
					shout = r.id_sh[0];
				else if (r.ir == sbst_pkg::OP_EXTEST
					|| r.ir == sbst_pkg::OP_SAMPLE_Z
					|| r.ir == sbst_pkg::OP_SAMPLE_PRE)
					shout = r.bs_sh[0];
				else
					shout = r.byp; // bypass and reserved codes
			end
		endcase
		if (rise)
		begin
			// actions of the current state, then move
			unique case (r.st)
				sbst_pkg::ST_CAP_IR:
					next_r.ir_sh = {1'b0, sbst_pkg::IR_CAPT_PAT};
				sbst_pkg::ST_SH_IR:
					next_r.ir_sh = {tdi_s, r.ir_sh[2:1]};
				sbst_pkg::ST_UP_IR:
					next_r.ir = r.ir_sh;
				sbst_pkg::ST_CAP_DR:
				begin
					next_r.id_sh = sbst_pkg::IDENT_CODE;
					next_r.byp   = 1'b0;
					next_r.bs_sh = pin_s;
				end
				sbst_pkg::ST_SH_DR:
				begin
					next_r.id_sh = {tdi_s, r.id_sh[31:1]};
					next_r.byp   = tdi_s;
					next_r.bs_sh = {tdi_s, r.bs_sh[BLEN-1:1]};
				end
				sbst_pkg::ST_UP_DR:
				begin
					if (r.ir == sbst_pkg::OP_EXTEST
						|| r.ir == sbst_pkg::OP_SAMPLE_PRE)
						next_r.bs_up = r.bs_sh;
				end
				default:
				begin
					// no register action in other states
				end
			endcase
			// state graph driven by mode select
			unique case (r.st)
				sbst_pkg::ST_RESET:
					next_r.st = tms_s ? sbst_pkg::ST_RESET : sbst_pkg::ST_IDLE;
				sbst_pkg::ST_IDLE, sbst_pkg::ST_UP_DR, sbst_pkg::ST_UP_IR:
					next_r.st = tms_s ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_IDLE;
				sbst_pkg::ST_SEL_DR:
					next_r.st = tms_s ? sbst_pkg::ST_SEL_IR : sbst_pkg::ST_CAP_DR;
				sbst_pkg::ST_CAP_DR, sbst_pkg::ST_SH_DR, sbst_pkg::ST_EX2_DR:
					next_r.st = tms_s ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
				sbst_pkg::ST_EX1_DR:
					next_r.st = tms_s ? sbst_pkg::ST_UP_DR : sbst_pkg::ST_PA_DR;
				sbst_pkg::ST_PA_DR:
					next_r.st = tms_s ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PA_DR;
				sbst_pkg::ST_SEL_IR:
					next_r.st = tms_s ? sbst_pkg::ST_RESET : sbst_pkg::ST_CAP_IR;
				sbst_pkg::ST_CAP_IR, sbst_pkg::ST_SH_IR, sbst_pkg::ST_EX2_IR:
					next_r.st = tms_s ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
				sbst_pkg::ST_EX1_IR:
					next_r.st = tms_s ? sbst_pkg::ST_UP_IR : sbst_pkg::ST_PA_IR;
				sbst_pkg::ST_PA_IR:
					next_r.st = tms_s ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PA_IR;
				default:
					next_r.st = sbst_pkg::ST_RESET; // illegal code recovers
			endcase
		end
		// reset state reloads ident and presets the enable cell
		if (r.st == sbst_pkg::ST_RESET)
		begin
			next_r.ir = sbst_pkg::OP_IDENT;
			next_r.bs_up[sbst_pkg::OE_CELL] = 1'b1;
		end
		// data out changes only on tck fall
		if (fall)
		begin
			next_r.tdo_oe = (r.st == sbst_pkg::ST_SH_IR)
				|| (r.st == sbst_pkg::ST_SH_DR);
			next_r.tdo_o  = shout;
		end
		// sram bus control
		next_r.ext = (next_r.ir == sbst_pkg::OP_EXTEST);
		if (next_r.ir == sbst_pkg::OP_SAMPLE_Z)
			next_r.oe = 1'b0;
		else if (next_r.ext)
			next_r.oe = next_r.bs_up[sbst_pkg::OE_CELL];
		else
			next_r.oe = 1'b1;
	end

	// one register for all state; reset equals power-up state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r        <= '0;
			r.st     <= sbst_pkg::ST_RESET;
			r.ir     <= sbst_pkg::OP_IDENT;
			r.bs_up[sbst_pkg::OE_CELL] <= 1'b1;
			r.oe     <= 1'b1;
		end
		else
			r <= next_r;
	end

	assign link.tdo_o   = r.tdo_o;
	assign link.tdo_oe  = r.tdo_oe;
	assign pin_drive    = r.bs_up;
	assign extest_on    = r.ext;
	assign sram_out_en  = r.oe;
endmodule // sbst_tap
`default_nettype wire

//--- hdl/sbst_pkg.sv
// shared constants for the sram boundary scan test port and its controller
package sbst_pkg;
	// instruction register
	localparam int          IR_W          = 3;
	localparam logic [2:0]  OP_EXTEST     = 3'h0;
	localparam logic [2:0]  OP_IDENT      = 3'h1;
	localparam logic [2:0]  OP_SAMPLE_Z   = 3'h2;
	localparam logic [2:0]  OP_SAMPLE_PRE = 3'h4;
	localparam logic [2:0]  OP_BYPASS     = 3'h7;
	localparam logic [1:0]  IR_CAPT_PAT   = 2'h1;
	// identification word; value is arbitrary
	localparam logic [31:0] IDENT_CODE    = 32'h0A5A5001;
	localparam int          ID_W          = 32;
	// boundary register
	localparam int          BSR_LEN       = 107;
	localparam int          OE_CELL       = 47;
	localparam int          RESET_TMS_N   = 5;
	// tap states, one-hot
	typedef enum logic [15:0] {
		ST_RESET  = 16'h0001, ST_IDLE   = 16'h0002,
		ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
		ST_SH_DR  = 16'h0010, ST_EX1_DR = 16'h0020,
		ST_PA_DR  = 16'h0040, ST_EX2_DR = 16'h0080,
		ST_UP_DR  = 16'h0100, ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400, ST_SH_IR  = 16'h0800,
		ST_EX1_IR = 16'h1000, ST_PA_IR  = 16'h2000,
		ST_EX2_IR = 16'h4000, ST_UP_IR  = 16'h8000
	} sbst_state_e;
	// controller register map (apb byte addresses)
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STAT      = 8'h04;
	localparam logic [7:0]  REG_WDATA     = 8'h08;
	localparam logic [7:0]  REG_RDATA     = 8'h0C;
	// ctrl fields: [0] go, [1] ir target, [2] reset first; length and bit numbers below
	localparam int          CTL_LEN_LSB   = 8;
	localparam int          CTL_IR_BIT    = 1;
	localparam int          CTL_RST_BIT   = 2;
	localparam int          DIV_HALF      = 4;
endpackage

//--- hdl/sbst_if.sv
// link between the scan controller and the sram test port
`timescale 1ns/100ps
`default_nettype none
interface sbst_if;
	logic tck;     // test clock, made by controller
	logic tms;     // mode select
	logic tdi;     // serial data into device
	logic tdo_o;   // device data out value
	logic tdo_oe;  // device drives data out
	logic tdo;     // resolved wire level, pulled up when floated
	assign tdo = tdo_oe ? tdo_o : 1'b1;
	modport dev (input tck, input tms, input tdi,
		output tdo_o, output tdo_oe);
	modport ctl (output tck, output tms, output tdi, input tdo);
endinterface
`default_nettype wire

//--- hdl/sbst_sync.sv
// two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/100ps
`default_nettype none
module sbst_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta; // first stage, read only by q
	// plain two-stage capture
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= '0;
			q    <= '0;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // sbst_sync
`default_nettype wire

//--- hdl/sbst_ctl.sv
// scan controller: apb registers drive tck, tms and tdi sequences
`timescale 1ns/100ps
`default_nettype none
module sbst_ctl (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	sbst_if.ctl              link
);
	typedef struct packed {
		logic [31:0] wdata;  // bits to shift, lsb first
		logic [31:0] rdata;  // captured bits, lsb first entry
		logic [5:0]  len;    // bits left
		logic [5:0]  total;  // length of job
		logic        is_ir;  // target instruction register
		logic        busy;   // job running
		logic [3:0]  phase;  // tms steps index
		logic [2:0]  div;    // clock divider
		logic        tck;    // link clock
		logic        tms;    // mode select
		logic        tdi;    // data out
		logic [31:0] prd;    // read data
		logic        rdy;    // apb ready
		logic        err;    // apb error
	} sbst_ctl_s;

	sbst_ctl_s r;
	sbst_ctl_s next_r;
	logic tdo_s;     // synchronised tdo
	logic acc;       // apb access phase
	logic tick;      // divider enable
	logic [31:0] st; // status word

	sbst_sync #(.W(1)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       (link.tdo),
		.q       (tdo_s)
	);

	assign acc  = psel & penable & ~r.rdy;
	assign tick = (r.div == 3'(sbst_pkg::DIV_HALF - 1));
	assign st   = {26'h0, r.len[4:0], r.busy};

	// job: optional reset, then walk to shift, shift len bits, to idle
	always_comb
	begin
		next_r = r;
		next_r.rdy = 1'b0;
		next_r.err = 1'b0;
		next_r.div = tick ? 3'h0 : r.div + 3'h1;
		// apb slave, one wait cycle
		if (acc)
		begin
			next_r.rdy = 1'b1;
			next_r.prd = 32'h0;
			unique case (paddr)
				sbst_pkg::REG_CTRL:
				begin
					if (pwrite && !r.busy && pwdata[0])
					begin
						next_r.busy  = 1'b1;
						next_r.is_ir = pwdata[sbst_pkg::CTL_IR_BIT];
						next_r.len   = pwdata[sbst_pkg::CTL_LEN_LSB +: 6];
						next_r.total = pwdata[sbst_pkg::CTL_LEN_LSB +: 6];
						next_r.phase = pwdata[sbst_pkg::CTL_RST_BIT]
							? 4'h0 : 4'h5;
						next_r.rdata = 32'h0;
					end
				end
				sbst_pkg::REG_STAT:  next_r.prd = st;
				sbst_pkg::REG_WDATA:
				begin
					if (pwrite)
						next_r.wdata = pwdata;
					next_r.prd = r.wdata;
				end
				sbst_pkg::REG_RDATA: next_r.prd = r.rdata;
				default:             next_r.err = 1'b1;
			endcase
		end
		// link sequencer; tms set at fall, tdo taken at the next fall
		if (r.busy && tick)
		begin
			next_r.tck = ~r.tck;
			if (r.tck)
			begin
				// falling edge: take the bit shown for the last shift
				// rise; at the rise it has not yet crossed the sync
				if ((r.phase == 4'h9 && r.len != r.total)
					|| (r.phase == 4'hA && r.total != 6'h0))
					next_r.rdata = {tdo_s, r.rdata[31:1]};
				// then set up next tms and tdi
				// phases 0-4 reset (five highs), 5 idle, 6 sel-dr,
				// 7 sel-ir when ir, 8 capture, 12 to shift, 9 shift,
				// 10 exit, 11 update
				if (r.phase < 4'h5)
					next_r.tms = 1'b1;
				else if (r.phase == 4'h5)
					next_r.tms = 1'b0;
				else if (r.phase == 4'h6)
					next_r.tms = 1'b1;
				else if (r.phase == 4'h7)
					next_r.tms = r.is_ir;
				else if (r.phase == 4'h8)
					next_r.tms = 1'b0;
				else if (r.phase == 4'h9)
				begin
					next_r.tms = (r.len == 6'h1);
					next_r.tdi = r.wdata[0];
				end
				else if (r.phase == 4'hA)
					next_r.tms = 1'b1;
				else if (r.phase == 4'hC)
					next_r.tms = (r.len == 6'h0); // empty job skips shift
				else
					next_r.tms = 1'b0;
			end
			else
			begin
				// rising edge: the device samples; advance phase
				if (r.phase == 4'h6 && !r.is_ir)
					next_r.phase = 4'h8;
				else if (r.phase == 4'h9)
				begin
					next_r.wdata = {1'b0, r.wdata[31:1]};
					next_r.len   = r.len - 6'h1;
					if (r.len == 6'h1)
						next_r.phase = 4'hA;
				end
				else if (r.phase == 4'hB)
				begin
					next_r.busy  = 1'b0;
					next_r.rdata = r.rdata >> (6'd32 - r.total);
				end
				else if (r.phase == 4'h8)
					next_r.phase = 4'hC; // capture rise, no shift yet
				else if (r.phase == 4'hC)
					next_r.phase = (r.len == 6'h0) ? 4'hA : 4'h9;
				else
					next_r.phase = r.phase + 4'h1;
			end
		end
	end

	// single state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r     <= '0;
			r.tck <= 1'b1; // parks high, as after every job
			r.tms <= 1'b1;
			r.tdi <= 1'b1;
		end
		else
			r <= next_r;
	end

	assign prdata   = r.prd;
	assign pready   = r.rdy;
	assign pslverr  = r.err;
	assign link.tck = r.tck;
	assign link.tms = r.tms;
	assign link.tdi = r.tdi;
endmodule // sbst_ctl
`default_nettype wire

//--- tb/sbst_assertions.sv
// wire-level checks on the scan link between controller and test port
`timescale 1ns/100ps
`default_nettype none
module sbst_assertions (
	input  wire logic pclk,    // system clock
	input  wire logic presetn, // async reset, low
	input  wire logic tck,     // test clock
	input  wire logic tms,     // mode select
	input  wire logic tdi,     // serial data in
	input  wire logic tdo_o,   // device data out value
	input  wire logic tdo_oe   // device drives data out
);
	// next-state nibble per state index: tables beat a long case
	localparam logic [63:0] NX0 = 64'h1BDDBBA146644311; // tms low
	localparam logic [63:0] NX1 = 64'h2FEFCC0287855920; // tms high
	logic [3:0] st;  // port state seen on the wire, 0 is reset
	logic [3:0] pst; // state before the last rise
	logic [3:0] idl; // clocks since tck moved, saturating
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// follow the port state from tms at each tck rise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st  <= 4'h0;
			pst <= 4'h0;
		end
		else if ($rose(tck))
		begin
			pst <= st;
			st  <= tms ? NX1[st*4 +: 4] : NX0[st*4 +: 4];
		end
	end
	// idle count: a parked link must leave data out floated
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idl <= 4'h0;
		else if ($changed(tck))
			idl <= 4'h0;
		else if (idl != 4'hF)
			idl <= idl + 4'h1;
	end
	AST_TCK_LOW: assert property ($fell(tck) |-> !tck [*4] ##1 tck)
		else $error("tck low phase not four clocks");
	AST_MOVE_AT_FALL: assert property
		(($changed(tms) || $changed(tdi)) |-> $fell(tck))
		else $error("tms or tdi moved off the tck fall");
	AST_TMS_HOLD: assert property ($rose(tck) |-> $stable(tms) [*3])
		else $error("tms not held across tck rise");
	AST_TDO_AT_FALL: assert property
		($rose(tck) && tdo_oe |=> $stable(tdo_o) [*3])
		else $error("data out moved near tck rise");
	AST_OE_SHIFT: assert property
		($rose(tck) |-> tdo_oe == (st == 4'h4 || st == 4'hB))
		else $error("data out enable outside shift states");
	AST_IR_CAPT: assert property
		($rose(tck) && st == 4'hB && pst == 4'hA |-> tdo_o ##8 !tdo_o)
		else $error("instruction capture pattern wrong");
	AST_RESET_FLOAT: assert property
		($rose(tck) && st == 4'h0 |-> !tdo_oe [*8])
		else $error("data out driven in reset state");
	AST_IDLE_FLOAT: assert property (idl == 4'hF |-> !tdo_oe)
		else $error("data out driven while link parked");
endmodule // sbst_assertions
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench: apb controller scanning the sram test port
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [106:0] PAT = 107'h5A5_C3C3_9696_F00F_1E2D_3C4B_5A69;
	localparam logic [31:0]  WD  = 32'h9ABC_DEF1; // shift-in word
	logic         pclk;      // 40 MHz system clock
	logic         presetn;   // async reset, low
	logic         psel;      // apb select
	logic         penable;   // apb access phase
	logic         pwrite;    // apb direction
	logic [7:0]   paddr;     // apb address
	logic [31:0]  pwdata;    // apb write data
	logic [31:0]  prdata;    // apb read data
	logic         pready;    // apb ready
	logic         pslverr;   // apb error
	logic [106:0] pin_in;    // sram pins seen by the port
	logic [106:0] pin_drive; // values driven under extest
	logic         extest_on; // extest current
	logic         out_en;    // sram output bus enable
	logic [31:0]  rd;        // last read word
	logic         err;       // last apb error
	logic [31:0]  want;      // expected scan result
	logic [106:0] ex;        // expected pin snapshot
	int           bad_count; // mismatches
	int           checks;    // comparisons made
	logic [2:0]   ops [3] = '{sbst_pkg::OP_SAMPLE_Z, sbst_pkg::OP_IDENT,
		sbst_pkg::OP_BYPASS}; // walked in turn, none reserved
	sbst_if link ();         // the two ends meet here
	sbst_ctl i_sbst_ctl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
	sbst_tap i_sbst_tap (.pclk(pclk), .presetn(presetn), .link(link),
		.pin_in(pin_in), .pin_drive(pin_drive), .extest_on(extest_on),
		.sram_out_en(out_en));
	sbst_assertions i_sbst_assertions (.pclk(pclk), .presetn(presetn),
		.tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo_o(link.tdo_o),
		.tdo_oe(link.tdo_oe));
	// free-running system clock
	always #12.5 pclk = ~pclk;
	// compare and count, report at once on a difference
	task automatic chk(input string what, input logic [106:0] seen,
		input logic [106:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1 && ++n < 64);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 64)
			bad_count++;
	endtask
	// one job: data word, go, poll until idle, fetch the result
	task automatic scan(input logic ir, input logic rst, input int len,
		input logic [31:0] w);
		int n;
		n = 0;
		apb(1'b1, sbst_pkg::REG_WDATA, w);
		apb(1'b1, sbst_pkg::REG_CTRL, (32'(len) << sbst_pkg::CTL_LEN_LSB)
			| (32'(rst) << sbst_pkg::CTL_RST_BIT)
			| (32'(ir) << sbst_pkg::CTL_IR_BIT) | 32'h1);
		do
			apb(1'b0, sbst_pkg::REG_STAT, 32'h0);
		while (rd[0] !== 1'b0 && ++n < 2000);
		if (n >= 2000)
			bad_count++;
		apb(1'b0, sbst_pkg::REG_RDATA, 32'h0);
		// only the shifted bits are meaningful
		if (len < 32)
			rd = rd & ((32'h1 << len) - 32'h1);
	endtask
	// verdict and end of run
	task automatic results;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// watchdog: run needs about 3k clocks, allow over ten times that
	initial
	begin
		#1000000;
		bad_count++;
		results();
	end
	// main sequence
	initial
	begin
		pclk      = 1'b0;
		presetn   = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0;
		pin_in    = PAT;
		bad_count = 0;
		checks    = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// power-up state and default instruction
		chk("out_en", out_en, 1'b1);
		chk("extest_on", extest_on, 1'b0);
		scan(1'b0, 1'b0, 32, 32'h0);
		chk("idcode", rd, sbst_pkg::IDENT_CODE);
		$display("test powerup done");
		// each instruction: capture pattern, bus state, data path
		foreach (ops[i])
		begin
			scan(1'b1, 1'b0, 3, 32'(ops[i]));
			chk("ir capture", rd, 3'h1);
			chk("bus", out_en, ops[i] != sbst_pkg::OP_SAMPLE_Z);
			scan(1'b0, 1'b0, 32, WD);
			want = (ops[i] == sbst_pkg::OP_IDENT) ? sbst_pkg::IDENT_CODE :
				(ops[i] == sbst_pkg::OP_BYPASS) ? WD << 1 : PAT[31:0];
			chk("dr path", rd, want);
			chk("bus held", out_en, ops[i] != sbst_pkg::OP_SAMPLE_Z);
		end
		$display("test instructions done");
		// preload the enable cell both ways, then enter extest
		for (int v = 1; v >= 0; v--)
		begin
			pin_in[79] <= v[0]; // settled long before capture
			ex = {PAT[106:80], v[0], PAT[78:0]};
			scan(1'b1, 1'b0, 3, 32'(sbst_pkg::OP_SAMPLE_PRE));
			scan(1'b0, 1'b0, 32, WD);
			chk("snapshot", rd, ex[31:0]);
			chk("preload", pin_drive, {WD, ex[106:32]});
			scan(1'b1, 1'b0, 3, 32'(sbst_pkg::OP_EXTEST));
			chk("extest", extest_on, 1'b1);
			chk("oe cell", out_en, v[0]);
			chk("drive", pin_drive, {WD, ex[106:32]});
		end
		$display("test extest done");
		// five tms highs bring back the default instruction
		scan(1'b0, 1'b1, 32, 32'h0);
		chk("id after reset", rd, sbst_pkg::IDENT_CODE);
		chk("extest off", extest_on, 1'b0);
		chk("oe preset", out_en, 1'b1);
		scan(1'b1, 1'b0, 3, 32'(sbst_pkg::OP_EXTEST));
		chk("oe cell preset", out_en, 1'b1);
		$display("test port reset done");
		// unmapped register refused, mapped one accepted
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", err, 1'b1);
		apb(1'b1, sbst_pkg::REG_WDATA, 32'h0);
		chk("mapped", err, 1'b0);
		$display("test bus errors done");
		results();
	end
endmodule // testbench
`default_nettype wire
